// [hw/oms_top.sv]
/*
  Operating mode select and reset sequencing with an APB register slave.
  Holds the mode monitor latch, the external bus enable, the area width
  configuration and a status word; sequences pin and watchdog resets.
  Assumes mode pins and the reset pin are asynchronous, the watchdog
  overflow comes from logic on clk_i, and the APB master is on clk_i.
*/
// The register addresses and register access over APB were chosen for this implementation.
// What this block does
// - Decode pin codes into six advanced modes
// - Modes 1,2,4 expand; ROM only mode 4
// - Bus 16-bit if bus enabled and any area 16-bit
// - Mode 7 single-chip, may expand later
// - Modes 3,5 boot, ROM and flash programming
// - Monitor bits 7..3 read zero, ignore writes
// - Monitor bits 2..0 mirror pins, read-only
// - Read latches pins; reset clears latch
// - Reset pin low halts all, masks interrupts
// - Reset pin rising starts exception handling in a defined mode
// - Watchdog overflow acts as external reset
// - Bus enable fixed 1 or writable, reset 0
`timescale 1ns/100ps
module oms_top (
  input  wire logic                        clk_i,                // System clock, 100 MHz
  input  wire logic                        reset_i,              // Synchronous reset, active high
  input  wire logic                        mode_pin_high_i,      // Mode pin, high
  input  wire logic                        mode_pin_mid_i,       // Mode pin, middle
  input  wire logic                        mode_pin_low_i,       // Mode pin, low
  input  wire logic                        reset_input_n_i,      // Reset pin, active low
  input  wire logic                        wdt_overflow_i,       // Watchdog overflow pulse
  input  wire logic                        psel_i,               // APB select
  input  wire logic                        penable_i,            // APB enable
  input  wire logic                        pwrite_i,             // APB write
  input  wire logic [oms_pkg::APB_AW-1:0]  paddr_i,              // APB byte address
  input  wire logic [31:0]                 pwdata_i,             // APB write data
  output logic      [31:0]                 prdata_o,             // APB read data
  output logic                             pready_o,             // APB ready
  output logic                             pslverr_o,            // APB error
  output logic                             cpu_halt_o,           // Processor held in reset
  output logic                             periph_reset_o,       // Peripherals held in reset
  output logic                             irq_mask_o,           // All interrupts masked
  output logic                             reset_exception_o,    // Reset exception handling
  output logic                             mode_valid_o,         // A defined mode is selected
  output logic      [2:0]                  mode_number_o,        // Selected mode number
  output logic                             rom_enable_o,         // On-chip ROM enabled
  output logic                             flash_prog_enable_o,  // Flash program/erase allowed
  output logic                             external_bus_enable_o,// External bus enabled
  output logic                             bus_16bit_o           // External bus is 16 bits
);
  import oms_pkg::*;

  // Synchronised pins
  logic [3:0]   pins_sync;
  logic [2:0]   mode_pins;
  logic         rst_pin;
  oms_mode_t    mode_now;

  // Registers
  oms_state_t   state_r;
  oms_state_t   state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic         rst_pin_d_r;
  logic         wdt_cause_r;
  oms_mode_t    mode_r;
  logic [2:0]   mon_seen_r;
  logic         external_bus_enable_r;
  logic [AREA_W-1:0] area_r;
  logic [31:0]  prdata_r;
  logic         pready_r;
  logic         pslverr_r;
  logic         halt_r;
  logic         exc_r;
  logic         bus16_r;

  // Decode helpers
  logic         enter_reset;
  logic         pin_rise;
  logic         setup;
  logic         done;
  logic         wr_en;
  logic         mapped;
  logic [31:0]  rd_data;
  logic         in_reset;

  oms_sync #(
    .W(4)
  ) u_sync (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .async_i ({reset_input_n_i, mode_pin_high_i, mode_pin_mid_i, mode_pin_low_i}),
    .sync_o  (pins_sync)
  );

  assign mode_pins = pins_sync[2:0];
  assign rst_pin   = pins_sync[3];

  oms_decode u_decode (
    .pins_i (mode_pins),
    .mode_o (mode_now)
  );

  // pins sampled continuously; stable by board
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_r <= '0;
    end else begin
      mode_r <= mode_now;
    end
  end

  assign enter_reset = ~rst_pin | wdt_overflow_i;
  assign pin_rise    = rst_pin & ~rst_pin_d_r;
  assign in_reset    = (state_r == ST_RESET);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rst_pin_d_r <= 1'b0;
    end else begin
      rst_pin_d_r <= rst_pin;
    end
  end

  // Remembers a watchdog cause so release needs no pin edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdt_cause_r <= 1'b0;
    end else if (wdt_overflow_i) begin
      wdt_cause_r <= 1'b1;
    end else if (~rst_pin) begin
      wdt_cause_r <= 1'b0;
    end else if (state_nxt != ST_RESET) begin
      wdt_cause_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    if (enter_reset) begin
      state_nxt = ST_RESET;
      cnt_nxt   = wdt_overflow_i ? CNT_W'(WDT_CYCLES - 1) : '0;
    end else begin
      case (state_r)
        ST_RESET: begin
          if (wdt_cause_r && cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
          // no start without a defined mode
          end else if (mode_r.valid && (wdt_cause_r || pin_rise)) begin
            state_nxt = ST_EXCEPTION;
            cnt_nxt   = CNT_W'(EXC_CYCLES - 1);
          end
        end
        ST_EXCEPTION: begin
          if (cnt_r == '0) begin
            state_nxt = ST_EXECUTE;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        ST_EXECUTE: begin
          state_nxt = ST_EXECUTE;
        end
        default: begin
          state_nxt = ST_RESET;
          cnt_nxt   = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r <= ST_RESET;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      halt_r <= 1'b1;
      exc_r  <= 1'b0;
    end else begin
      halt_r <= (state_nxt == ST_RESET);
      exc_r  <= (state_nxt == ST_EXCEPTION);
    end
  end

  // APB handshake: one wait-free access phase
  assign setup  = psel_i & ~penable_i;
  assign done   = psel_i & penable_i & pready_r;
  assign wr_en  = done & pwrite_i & ~pslverr_r;
  assign mapped = (paddr_i == OFS_MONITOR) || (paddr_i == OFS_SYSCTL) ||
                  (paddr_i == OFS_AREA) || (paddr_i == OFS_STATUS);

  always_comb begin
    rd_data = '0;
    case (paddr_i)
      OFS_MONITOR: begin
        rd_data[MON_SEEN_LSB +: MON_SEEN_W] = mode_pins;
      end
      OFS_SYSCTL: begin
        rd_data[SYS_EXTERNAL_BUS_ENABLE_BIT] = external_bus_enable_r;
      end
      OFS_AREA: begin
        rd_data[AREA_W-1:0] = area_r;
      end
      OFS_STATUS: begin
        rd_data[ST_BUS16_BIT]        = bus16_r;
        rd_data[ST_FLASH_BIT]        = mode_r.flash_prog;
        rd_data[ST_EXT_BIT]          = mode_r.ext_allowed;
        rd_data[ST_ROM_BIT]          = mode_r.rom_en;
        rd_data[ST_NUM_LSB +: 3]     = mode_r.number;
        rd_data[ST_VALID_BIT]        = mode_r.valid;
        rd_data[ST_STATE_LSB +: 2]   = state_r;
        // latched pins from the last monitor read
        rd_data[ST_SEEN_LSB +: MON_SEEN_W] = mon_seen_r;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else if (setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= ~mapped;
      prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_data;
    end else begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  // latch pins on read, clear on reset
  always_ff @(posedge clk_i) begin
    if (reset_i || enter_reset || in_reset) begin
      mon_seen_r <= MON_SEEN_RESET;
    end else if (setup && !pwrite_i && paddr_i == OFS_MONITOR) begin
      mon_seen_r <= mode_pins;
    end
  end

  // external bus enable fixed or writable
  // expansion in modes 1, 2 and 4
  // mode 7 switches only once running
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      external_bus_enable_r <= EXTERNAL_BUS_ENABLE_RESET;
    end else if (mode_r.external_bus_enable_fixed) begin
      external_bus_enable_r <= 1'b1;
    end else if (enter_reset || in_reset || !mode_r.valid) begin
      external_bus_enable_r <= EXTERNAL_BUS_ENABLE_RESET;
    end else if (wr_en && paddr_i == OFS_SYSCTL && state_r == ST_EXECUTE) begin
      external_bus_enable_r <= pwdata_i[SYS_EXTERNAL_BUS_ENABLE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      area_r <= AREA_INIT8;
    end else if (enter_reset || in_reset) begin
      area_r <= mode_r.init16 ? AREA_INIT16 : AREA_INIT8;
    end else if (wr_en && paddr_i == OFS_AREA) begin
      area_r <= pwdata_i[AREA_W-1:0];
    end
  end

  // any 16-bit area widens the bus while the external bus is enabled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus16_r <= 1'b0;
    end else begin
      bus16_r <= external_bus_enable_r & (|area_r);
    end
  end

  assign prdata_o              = prdata_r;
  assign pready_o              = pready_r;
  assign pslverr_o             = pslverr_r;
  assign cpu_halt_o            = halt_r;
  assign periph_reset_o        = halt_r;
  assign irq_mask_o            = halt_r;
  assign reset_exception_o     = exc_r;
  assign mode_valid_o          = mode_r.valid;
  assign mode_number_o         = mode_r.number;
  assign rom_enable_o          = mode_r.rom_en;
  assign flash_prog_enable_o   = mode_r.flash_prog;
  assign external_bus_enable_o = external_bus_enable_r;
  assign bus_16bit_o           = bus16_r;
endmodule

// [hw/oms_pkg.sv]
/*
  Shared constants and types of the operating mode select block: APB register
  offsets and fields, reset values, mode pin codes, timing counts and the
  decoded mode carrier.
  Assumes a 100 MHz system clock and a 12-bit APB byte address.
*/
package oms_pkg;

  // Clock
  localparam int unsigned CLK_PERIOD_NS   = 10;

  // Reset exception handling length and watchdog reset hold
  localparam int unsigned EXC_TIME_NS     = 200;
  localparam int unsigned EXC_CYCLES_RAW  = (EXC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXC_CYCLES      = (EXC_CYCLES_RAW < 1) ? 1 : EXC_CYCLES_RAW;
  localparam int unsigned WDT_HOLD_NS     = 500;
  localparam int unsigned WDT_CYCLES_RAW  = (WDT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WDT_CYCLES      = (WDT_CYCLES_RAW < 1) ? 1 : WDT_CYCLES_RAW;
  localparam int unsigned CNT_W           = 8;

  // APB map
  localparam int unsigned APB_AW          = 12;
  localparam logic [11:0] OFS_MONITOR     = 12'h000;
  localparam logic [11:0] OFS_SYSCTL      = 12'h004;
  localparam logic [11:0] OFS_AREA        = 12'h008;
  localparam logic [11:0] OFS_STATUS      = 12'h00c;

  // Field positions
  localparam int unsigned MON_SEEN_LSB    = 0;
  localparam int unsigned MON_SEEN_W      = 3;
  localparam int unsigned MON_W           = 8;
  localparam int unsigned SYS_EXTERNAL_BUS_ENABLE_BIT    = 1;
  localparam int unsigned AREA_W          = 8;
  localparam int unsigned ST_BUS16_BIT    = 0;
  localparam int unsigned ST_FLASH_BIT    = 1;
  localparam int unsigned ST_EXT_BIT      = 2;
  localparam int unsigned ST_ROM_BIT      = 3;
  localparam int unsigned ST_NUM_LSB      = 4;
  localparam int unsigned ST_VALID_BIT    = 7;
  localparam int unsigned ST_STATE_LSB    = 8;
  localparam int unsigned ST_SEEN_LSB     = 10;

  // Reset values
  localparam logic [2:0]  MON_SEEN_RESET  = 3'h0;
  localparam logic        EXTERNAL_BUS_ENABLE_RESET      = 1'b0;
  localparam logic [7:0]  AREA_INIT16     = 8'hff;
  localparam logic [7:0]  AREA_INIT8      = 8'h00;

  // Mode pin codes, high pin first
  localparam logic [2:0]  PINS_MODE1      = 3'h1;
  localparam logic [2:0]  PINS_MODE2      = 3'h2;
  localparam logic [2:0]  PINS_MODE3      = 3'h3;
  localparam logic [2:0]  PINS_MODE4      = 3'h4;
  localparam logic [2:0]  PINS_MODE5      = 3'h5;
  localparam logic [2:0]  PINS_MODE7      = 3'h7;

  // Decoded mode; all modes run the processor in advanced addressing
  typedef struct packed {
    logic       valid;
    logic [2:0] number;
    logic       rom_en;
    logic       ext_allowed;
    logic       external_bus_enable_fixed;
    logic       flash_prog;
    logic       init16;
    logic       single_start;
  } oms_mode_t;

  typedef enum logic [1:0] {
    ST_RESET,
    ST_EXCEPTION,
    ST_EXECUTE
  } oms_state_t;

endpackage

// [hw/oms_sync.sv]
/*
  Two flip-flop synchroniser for a group of asynchronous levels.
  Assumes each bit is a slow level; the bits are not coherent as a word.
*/
`timescale 1ns/100ps
module oms_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,    // System clock
  input  wire logic         reset_i,  // Synchronous reset, active high
  input  wire logic [W-1:0] async_i,  // Asynchronous levels
  output logic      [W-1:0] sync_o    // Synchronised levels
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule

// [hw/oms_decode.sv]
/*
  Combinational decoder from the three mode pin levels to the mode features.
  Assumes synchronised pin levels on its input.
*/
`timescale 1ns/100ps
module oms_decode (
  input  wire logic [2:0]        pins_i,  // Mode pins, high pin in bit 2
  output oms_pkg::oms_mode_t     mode_o   // Decoded mode features
);
  import oms_pkg::*;

  always_comb begin
    mode_o = '0;
    case (pins_i)
      PINS_MODE1: begin
        mode_o = '{valid: 1'b1, number: 3'h1, rom_en: 1'b0, ext_allowed: 1'b1,
                   external_bus_enable_fixed: 1'b1, flash_prog: 1'b0, init16: 1'b1, single_start: 1'b0};
      end
      PINS_MODE2: begin
        mode_o = '{valid: 1'b1, number: 3'h2, rom_en: 1'b0, ext_allowed: 1'b1,
                   external_bus_enable_fixed: 1'b1, flash_prog: 1'b0, init16: 1'b0, single_start: 1'b0};
      end
      PINS_MODE3: begin
        mode_o = '{valid: 1'b1, number: 3'h3, rom_en: 1'b1, ext_allowed: 1'b0,
                   external_bus_enable_fixed: 1'b0, flash_prog: 1'b1, init16: 1'b0, single_start: 1'b1};
      end
      PINS_MODE4: begin
        mode_o = '{valid: 1'b1, number: 3'h4, rom_en: 1'b1, ext_allowed: 1'b1,
                   external_bus_enable_fixed: 1'b1, flash_prog: 1'b0, init16: 1'b0, single_start: 1'b0};
      end
      PINS_MODE5: begin
        mode_o = '{valid: 1'b1, number: 3'h5, rom_en: 1'b1, ext_allowed: 1'b0,
                   external_bus_enable_fixed: 1'b0, flash_prog: 1'b1, init16: 1'b0, single_start: 1'b1};
      end
      PINS_MODE7: begin
        mode_o = '{valid: 1'b1, number: 3'h7, rom_en: 1'b1, ext_allowed: 1'b0,
                   external_bus_enable_fixed: 1'b0, flash_prog: 1'b0, init16: 1'b0, single_start: 1'b1};
      end
      default: begin
        mode_o = '0;
      end
    endcase
  end
endmodule

// [verif/oms_board.sv]
/*
  Board model: the three mode strap pins and the reset pin.
  Assumes the bench asks for a pin reset whenever it wants a new strap code.
*/
`timescale 1ns/100ps
module oms_board (
  input  wire logic       clk_i,     // Clock
  input  wire logic [2:0] code_i,    // Wanted strap code
  input  wire logic       hold_i,    // Hold reset pin low
  output logic            reset_n_o, // Reset pin
  output logic [2:0]      pins_o     // Straps, high first
);
  initial begin
    reset_n_o = 1'b0;
    pins_o    = 3'h0;
  end
  always @(posedge clk_i) begin
    reset_n_o <= !hold_i;
  end
  always @(posedge clk_i) begin
    if (!reset_n_o) begin
      pins_o <= code_i;
    end
  end
endmodule

// [verif/oms_top_assertions.sv]
/*
  Checker of the mode select top, bound to it.
  Assumes one clock domain and sees the top's ports only.
*/
`timescale 1ns/100ps
module oms_top_checker (
  input wire logic                        clk_i,                // Clock
  input wire logic                        reset_i,              // Reset
  input wire logic                        mode_pin_high_i,      // Strap
  input wire logic                        mode_pin_mid_i,       // Strap
  input wire logic                        mode_pin_low_i,       // Strap
  input wire logic                        reset_input_n_i,      // Reset pin
  input wire logic                        wdt_overflow_i,       // Watchdog
  input wire logic                        psel_i,               // APB
  input wire logic                        penable_i,            // APB
  input wire logic                        pwrite_i,             // APB
  input wire logic [oms_pkg::APB_AW-1:0]  paddr_i,              // APB
  input wire logic [31:0]                 prdata_o,             // APB
  input wire logic                        pready_o,             // APB
  input wire logic                        cpu_halt_o,           // Halt
  input wire logic                        irq_mask_o,           // Mask
  input wire logic                        reset_exception_o,    // Exception
  input wire logic                        mode_valid_o,         // Valid
  input wire logic [2:0]                  mode_number_o,        // Mode
  input wire logic                        rom_enable_o,         // ROM
  input wire logic                        flash_prog_enable_o,  // Flash
  input wire logic                        external_bus_enable_o // Bus enable
);
  import oms_pkg::*;
  logic [2:0] pins;
  assign pins = {mode_pin_high_i, mode_pin_mid_i, mode_pin_low_i};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  function automatic logic [2:0] mode_of(input logic [2:0] p);
    return (p == 3'h0 || p == 3'h6) ? 3'h0 : p;
  endfunction
  sequence s_rd_mon;
    psel_i && !penable_i && !pwrite_i && paddr_i == OFS_MONITOR;
  endsequence
  sequence s_running;
    mode_valid_o && !cpu_halt_o && !reset_exception_o;
  endsequence
  property p_decode;
    $stable(pins)[*5] |-> mode_number_o == mode_of(pins) && mode_valid_o == (mode_of(pins) != 3'h0);
  endproperty
  a_decode: assert property (p_decode) else $error("mode decode wrong");
  property p_rom; mode_valid_o |-> rom_enable_o == (mode_number_o inside {3'h3, 3'h4, 3'h5, 3'h7}); endproperty
  a_rom: assert property (p_rom) else $error("rom enable wrong");
  property p_flash; mode_valid_o |-> flash_prog_enable_o == (mode_number_o inside {3'h3, 3'h5}); endproperty
  a_flash: assert property (p_flash) else $error("flash enable wrong");
  property p_external_bus_enable; s_running ##0 mode_number_o inside {3'h1, 3'h2, 3'h4} |-> external_bus_enable_o; endproperty
  a_external_bus_enable: assert property (p_external_bus_enable) else $error("bus enable not fixed");
  property p_mon_rsvd; s_rd_mon ##1 pready_o |-> prdata_o[7:3] == 5'h0; endproperty
  a_mon_rsvd: assert property (p_mon_rsvd) else $error("monitor upper bits set");
  property p_mon_pins; $stable(pins)[*3] ##0 s_rd_mon ##1 pready_o |-> prdata_o[2:0] == $past(pins); endproperty
  a_mon_pins: assert property (p_mon_pins) else $error("monitor differs from pins");
  property p_pin_halt; !reset_input_n_i[*3] |=> cpu_halt_o && irq_mask_o; endproperty
  a_pin_halt: assert property (p_pin_halt) else $error("reset pin did not halt");
  property p_exc_entry; $fell(cpu_halt_o) |-> reset_exception_o; endproperty
  a_exc_entry: assert property (p_exc_entry) else $error("left reset without exception");
  property p_wdt; wdt_overflow_i |-> ##[1:2] cpu_halt_o && irq_mask_o; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not reset");
endmodule

bind oms_top oms_top_checker i_chk (
  .clk_i(clk_i), .reset_i(reset_i), .mode_pin_high_i(mode_pin_high_i), .mode_pin_mid_i(mode_pin_mid_i),
  .mode_pin_low_i(mode_pin_low_i), .reset_input_n_i(reset_input_n_i), .wdt_overflow_i(wdt_overflow_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .cpu_halt_o(cpu_halt_o), .irq_mask_o(irq_mask_o), .reset_exception_o(reset_exception_o),
  .mode_valid_o(mode_valid_o), .mode_number_o(mode_number_o), .rom_enable_o(rom_enable_o),
  .flash_prog_enable_o(flash_prog_enable_o), .external_bus_enable_o(external_bus_enable_o)
);

// [verif/operating_mode_select_tb.sv]
/*
  Testbench of the mode select top: strap sweep, APB registers, pin and
  watchdog resets. Assumes the board model and the bound checker.
*/
`timescale 1ns/100ps
module operating_mode_select_tb;
  import oms_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic        err;
  } oms_exp_t;
  logic clk_i = 0, reset_i = 1, hold = 1, wdt = 0, rst_n;
  logic psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, r;
  logic [2:0] code = 0, pins, num;
  logic pready_o, pslverr_o, halt, periph, irqm, exc, valid, rom, flash, external_bus_enable, bus16;
  oms_exp_t exp_q[$];
  oms_exp_t seen_e;
  int err_count = 0, compares = 0;

  always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

  oms_board i_board (.clk_i(clk_i), .code_i(code), .hold_i(hold), .reset_n_o(rst_n), .pins_o(pins));
  oms_top i_dut (
    .clk_i(clk_i), .reset_i(reset_i), .mode_pin_high_i(pins[2]), .mode_pin_mid_i(pins[1]),
    .mode_pin_low_i(pins[0]), .reset_input_n_i(rst_n), .wdt_overflow_i(wdt), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .cpu_halt_o(halt),
    .periph_reset_o(periph), .irq_mask_o(irqm), .reset_exception_o(exc), .mode_valid_o(valid),
    .mode_number_o(num), .rom_enable_o(rom), .flash_prog_enable_o(flash),
    .external_bus_enable_o(external_bus_enable), .bus_16bit_o(bus16)
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input oms_exp_t e);
    exp_q.push_back(e);
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] k);
    apb(1'b0, a, 32'h0, '{d, k, 1'b0});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '{32'h0, 32'h0, 1'b0});
  endtask

  // Completed transfers against the oldest note
  always @(posedge clk_i) begin
    if (pready_o === 1'b1 && psel_i && penable_i) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        seen_e = exp_q.pop_front();
        chk(prdata_o & seen_e.mask, seen_e.data & seen_e.mask);
        chk({31'h0, pslverr_o}, {31'h0, seen_e.err});
      end
    end
  end

  task automatic run_mode(input logic [2:0] m);
    logic ok, ext;
    ok = (m != 3'h0 && m != 3'h6);
    ext = (m == 3'h1 || m == 3'h2 || m == 3'h4);
    @(posedge clk_i);
    hold <= 1;
    code <= m;
    repeat (6) @(posedge clk_i);
    #1;
    chk({29'h0, halt, irqm, periph}, 32'h7);
    @(posedge clk_i);
    hold <= 0;
    repeat (5) @(posedge clk_i);
    #1;
    chk({31'h0, exc}, {31'h0, ok});
    repeat (EXC_CYCLES + 4) @(posedge clk_i);
    #1;
    chk({27'h0, halt, valid, num}, {27'h0, !ok, ok, ok ? m : 3'h0});
    chk({29'h0, rom, flash, external_bus_enable}, {29'h0, ok && m > 3'h2, m == 3'h3 || m == 3'h5, ext});
    chk({31'h0, bus16}, {31'h0, m == 3'h1});
    r = $urandom;
    rd(OFS_STATUS, 32'h0, 32'h1c00);
    rd(OFS_MONITOR, {29'h0, m}, 32'hff);
    rd(OFS_STATUS, {19'h0, ok ? m : 3'h0, 10'h0}, 32'h1c00);
    wr(OFS_MONITOR, r);
    rd(OFS_MONITOR, {29'h0, m}, 32'hff);
    if (ok) begin
      rd(OFS_AREA, {24'h0, m == 3'h1 ? AREA_INIT16 : AREA_INIT8}, 32'hff);
      wr(OFS_SYSCTL, r | 32'h2);
      rd(OFS_SYSCTL, 32'h2, 32'h2);
      wr(OFS_AREA, 32'h0);
      repeat (2) @(posedge clk_i);
      #1;
      chk({31'h0, bus16}, 32'h0);
      wr(OFS_AREA, 32'h1 << r[2:0]);
      repeat (2) @(posedge clk_i);
      #1;
      chk({31'h0, bus16}, 32'h1);
      wr(OFS_SYSCTL, r & ~32'h2);
      rd(OFS_SYSCTL, {30'h0, ext, 1'b0}, 32'h2);
    end
  endtask

  initial begin
    r = $urandom(71);
    repeat (16) @(posedge clk_i);
    reset_i <= 0;
    for (int c = 0; c < 8; c++) begin
      run_mode(3'(c));
    end
    apb(1'b0, 12'h010, 32'h0, '{32'h0, 32'h0, 1'b1});
    wr(OFS_SYSCTL, 32'h2);
    @(posedge clk_i);
    wdt <= 1;
    @(posedge clk_i);
    wdt <= 0;
    @(posedge clk_i);
    #1;
    chk({29'h0, halt, irqm, periph}, 32'h7);
    repeat (WDT_CYCLES + EXC_CYCLES + 8) @(posedge clk_i);
    #1;
    chk({30'h0, halt, external_bus_enable}, 32'h0);
    tally_and_finish();
  end

  initial begin
    #(CLK_PERIOD_NS * 5000);
    err_count++;
    tally_and_finish();
  end
endmodule
